// ### src/quadrature_decoder_map.svh
// Register offsets, field positions, reset values and limits of the decoder.
`ifndef QUADRATURE_DECODER_MAP_SVH
`define QUADRATURE_DECODER_MAP_SVH
`define QD_OFS_CTRL      12'h000
`define QD_OFS_STATUS    12'h004
`define QD_OFS_POS       12'h008
`define QD_OFS_SPEED     12'h00c
`define QD_OFS_TBASE     12'h010
`define QD_BIT_EN        0
`define QD_BIT_POSITION_MEASURE_ENABLE     1
`define QD_BIT_SPEED_MEASURE_ENABLE   2
`define QD_BIT_TRANS     3
`define QD_BIT_EDGAB     4
`define QD_BIT_INVERT_PHASE_A      5
`define QD_BIT_INVERT_PHASE_B      6
`define QD_BIT_INVERT_INDEX    7
`define QD_BIT_EXCH      8
`define QD_BIT_IDXB      9
`define QD_BIT_MISSING_PULSE_AUTOCORRECT     10
`define QD_FILT_LSB      16
`define QD_CMP_LSB       24
`define QD_CTRL_RESET    32'h0001_0000
`define QD_FILT_MIN      6'h01
`define QD_TBASE_RESET   32'h0000_00ff
`define QD_ST_IDX        0
`define QD_ST_DIRECTION_CHANGE_FLAG     1
`define QD_ST_QUADRATURE_ERROR_FLAG       2
`define QD_ST_MPE        3
`define QD_ST_DIR        8
`endif

// ### src/quadrature_decoder_pkg.sv
// Types shared by the quadrature decoder files.
package quadrature_decoder_pkg;
  typedef struct packed {
    logic       autocorrect;
    logic       index_on_b;
    logic       exchange;
    logic       inv_idx;
    logic       inv_b;
    logic       inv_a;
    logic       both_edges;
    logic       transparent;
    logic       speed_en;
    logic       pos_en;
    logic       enable;
  } qd_ctrl_type;
  typedef struct packed {
    logic a;
    logic b;
    logic idx;
  } qd_phase_type;
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_DATA = 3'b010,
    RD_HOLD = 3'b100
  } rd_state_type;
endpackage

// ### src/qd_filter.sv
// Glitch filter: a level is taken only after it held threshold+1 clocks.
`timescale 1ns/100ps
module qd_filter
  import quadrature_decoder_pkg::*;
#(
  parameter int WIDTH = 6
)
(
  input  wire logic             clk,       // Peripheral clock.
  input  wire logic             arst_n,    // Asynchronous reset.
  input  wire logic             run,       // Filter active.
  input  wire logic [WIDTH-1:0] threshold, // Minimum stable cycles minus one.
  input  wire logic             raw,       // Unfiltered level.
  output logic                  clean      // Filtered level.
);
  logic [WIDTH-1:0] cnt_r;
  logic             clean_r;
  assign clean = clean_r;
  // The counter restarts on every bounce, so short pulses never pass.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r   <= '0;
      clean_r <= 1'b0;
    end
    else if (!run)
    begin
      cnt_r   <= '0;
      clean_r <= raw;
    end
    else if (raw == clean_r)
      cnt_r <= '0;
    else if (cnt_r >= threshold)
    begin
      cnt_r   <= '0;
      clean_r <= raw; // [RULE13]
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end
endmodule

// ### src/quadrature_decoder.sv
// Quadrature decoder front end with an AXI4-Lite register slave.
//
// Notes on behaviour
// [RULE1] Enable runs filtering, edges and decoding; cleared, everything is idle.
// [RULE2] Software enabling the decoder also sets position or speed enable.
// [RULE3] Position enable lets channels 0 and 1 count position.
// [RULE4] Speed enable measures edges on channel 0 over a channel 2 period; the code counts cnt_edge over tbase_r plus one clocks instead.
// [RULE5] Transparent mode drops direction decoding but keeps filter and edges.
// [RULE6] Edges are counted on phase A only, or on both phases.
// [RULE7] Phase A comes from line A0 and may be inverted.
// [RULE8] Phase B comes from line B0 and may be inverted.
// [RULE9] Index comes from line A1 and may be inverted.
// [RULE10] Exchange swaps phase A and phase B before decoding.
// [RULE11] Index is taken from line B0 when index on phase B is set.
// [RULE12] Autocorrect enables missing pulse detection and correction.
// [RULE13] Pulses shorter than threshold plus one clocks are discarded.
// [RULE14] A zero missing pulse limit never sets the missing pulse flag.
// [RULE15] Limit consecutive missing pulses raise the missing pulse flag.
// [RULE16] Each rising edge of the processed index raises the index flag.
// [RULE17] A reversal of decoded direction raises the direction change flag.
// [RULE18] An illegal quadrature sequence raises the quadrature error flag.
// [RULE19] A leading B means reverse, a leading A means forward.
// [RULE20] Both phases changing in one sample is an error; position holds. With autocorrect and a known direction, position moves by two.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`include "quadrature_decoder_map.svh"
module quadrature_decoder
  import quadrature_decoder_pkg::*;
#(
  parameter int POS_W = 32
)
(
  input  wire logic        clk,           // 250 MHz peripheral clock.
  input  wire logic        arst_n,        // Asynchronous reset, active low.
  input  wire logic        timer_line_a0, // Phase A pin.
  input  wire logic        timer_line_b0, // Phase B pin.
  input  wire logic        timer_line_a1, // Index pin.
  input  wire logic [11:0] s_axi_awaddr,  // Write address.
  input  wire logic        s_axi_awvalid, // Write address valid.
  output logic             s_axi_awready, // Write address ready.
  input  wire logic [31:0] s_axi_wdata,   // Write data.
  input  wire logic [3:0]  s_axi_wstrb,   // Write strobes.
  input  wire logic        s_axi_wvalid,  // Write data valid.
  output logic             s_axi_wready,  // Write data ready.
  output logic [1:0]       s_axi_bresp,   // Write response.
  output logic             s_axi_bvalid,  // Write response valid.
  input  wire logic        s_axi_bready,  // Write response ready.
  input  wire logic [11:0] s_axi_araddr,  // Read address.
  input  wire logic        s_axi_arvalid, // Read address valid.
  output logic             s_axi_arready, // Read address ready.
  output logic [31:0]      s_axi_rdata,   // Read data.
  output logic [1:0]       s_axi_rresp,   // Read response.
  output logic             s_axi_rvalid,  // Read data valid.
  input  wire logic        s_axi_rready   // Read data ready.
);
  logic [31:0]      ctrl_r;
  logic [31:0]      tbase_r;
  qd_ctrl_type      cfg;
  logic [5:0]       filt_thr;
  logic [7:0]       cmp_lim;
  qd_phase_type     pin;
  qd_phase_type     flt;
  logic             a_q_r, b_q_r, idx_q_r;
  logic             dir_r, dir_valid_r;
  logic [POS_W-1:0] pos_r;
  logic [31:0]      speed_r, spd_cnt_r, tb_cnt_r;
  logic [7:0]       miss_r;
  logic [3:0]       flag_r;
  logic             ev_idx, ev_dir, ev_quadrature_error_flag, ev_mpe;
  logic             edge_a, edge_b, step, fwd, both_chg, cnt_edge;
  logic             aw_got_r, w_got_r;
  logic [11:0]      aw_addr_r;
  logic [31:0]      w_data_r;
  logic [3:0]       w_strb_r;
  logic             clr_st;
  logic [3:0]       clr_mask;
  rd_state_type     rd_state_r;
  logic [31:0]      rdata_r;
  logic             rd_bad_r;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        res[i*8 +: 8] = nw[i*8 +: 8];
    return res;
  endfunction

  assign cfg      = ctrl_r[`QD_BIT_MISSING_PULSE_AUTOCORRECT:`QD_BIT_EN];
  assign filt_thr = ctrl_r[`QD_FILT_LSB +: 6];
  assign cmp_lim  = ctrl_r[`QD_CMP_LSB +: 8];

  // Inversion sits ahead of the exchange, both ahead of the filters.
  always_comb
  begin
    logic pa, pb;
    pa      = timer_line_a0 ^ cfg.inv_a; // [RULE7]
    pb      = timer_line_b0 ^ cfg.inv_b; // [RULE8]
    pin.a   = cfg.exchange ? pb : pa; // [RULE10]
    pin.b   = cfg.exchange ? pa : pb; // [RULE10]
    pin.idx = (cfg.index_on_b ? timer_line_b0 : timer_line_a1)
              ^ cfg.inv_idx; // [RULE9] [RULE11]
  end

  qd_filter #(.WIDTH(6)) u_fa
  (
    .clk       (clk),
    .arst_n    (arst_n),
    .run       (cfg.enable),
    .threshold (filt_thr),
    .raw       (pin.a),
    .clean     (flt.a)
  );
  qd_filter #(.WIDTH(6)) u_fb
  (
    .clk       (clk),
    .arst_n    (arst_n),
    .run       (cfg.enable),
    .threshold (filt_thr),
    .raw       (pin.b),
    .clean     (flt.b)
  );
  qd_filter #(.WIDTH(6)) u_fi
  (
    .clk       (clk),
    .arst_n    (arst_n),
    .run       (cfg.enable),
    .threshold (filt_thr),
    .raw       (pin.idx),
    .clean     (flt.idx)
  );

  assign edge_a   = cfg.enable && (flt.a != a_q_r); // [RULE1]
  assign edge_b   = cfg.enable && (flt.b != b_q_r);
  assign both_chg = edge_a && edge_b; // [RULE20]
  assign step     = (edge_a ^ edge_b) && !cfg.transparent; // [RULE5]
  // Forward when A leads: after an A change A differs from B.
  assign fwd      = edge_a ? (flt.a != flt.b) : (flt.a == flt.b); // [RULE19]
  assign cnt_edge = edge_a || (cfg.both_edges && edge_b); // [RULE6]
  assign ev_idx   = cfg.enable && flt.idx && !idx_q_r; // [RULE16]
  assign ev_dir   = step && dir_valid_r && (fwd != dir_r); // [RULE17]
  assign ev_quadrature_error_flag  = both_chg && !cfg.transparent; // [RULE18]
  assign ev_mpe   = cfg.autocorrect && (cmp_lim != 8'h00)
                    && ev_quadrature_error_flag && (miss_r + 8'h01 >= cmp_lim); // [RULE14] [RULE15]

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      a_q_r   <= 1'b0;
      b_q_r   <= 1'b0;
      idx_q_r <= 1'b0;
    end
    else
    begin
      a_q_r   <= flt.a;
      b_q_r   <= flt.b;
      idx_q_r <= flt.idx;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dir_r       <= 1'b0;
      dir_valid_r <= 1'b0;
    end
    else if (!cfg.enable || cfg.transparent)
      dir_valid_r <= 1'b0;
    else if (step)
    begin
      dir_r       <= fwd;
      dir_valid_r <= 1'b1;
    end
  end

  // Position: a both-phase jump is a missed step; autocorrect adds or subtracts two, following the last decoded direction.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pos_r <= '0;
    else if (cfg.enable && cfg.pos_en) // [RULE3]
    begin
      if (step && cnt_edge)
        pos_r <= fwd ? pos_r + 1'b1 : pos_r - 1'b1;
      else if (ev_quadrature_error_flag && cfg.autocorrect && dir_valid_r) // [RULE12]
        pos_r <= dir_r ? pos_r + 2'd2 : pos_r - 2'd2;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      miss_r <= 8'h00;
    else if (!cfg.autocorrect || step)
      miss_r <= 8'h00;
    else if (ev_quadrature_error_flag)
      miss_r <= ev_mpe ? 8'h00 : miss_r + 8'h01; // [RULE15]
  end

  // Speed: edges counted over one time-base period.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tb_cnt_r  <= 32'h0000_0000;
      spd_cnt_r <= 32'h0000_0000;
      speed_r   <= 32'h0000_0000;
    end
    else if (!(cfg.enable && cfg.speed_en))
    begin
      tb_cnt_r  <= 32'h0000_0000;
      spd_cnt_r <= 32'h0000_0000;
    end
    else if (tb_cnt_r >= tbase_r) // [RULE4]
    begin
      tb_cnt_r  <= 32'h0000_0000;
      speed_r   <= spd_cnt_r + {31'h0, cnt_edge};
      spd_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      tb_cnt_r  <= tb_cnt_r + 32'h0000_0001;
      spd_cnt_r <= spd_cnt_r + {31'h0, cnt_edge};
    end
  end

  // Status flags are sticky; a new event beats a write-one clear.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flag_r <= 4'h0;
    else
      flag_r <= (flag_r & ~(clr_st ? clr_mask : 4'h0))
                | {ev_mpe, ev_quadrature_error_flag, ev_dir, ev_idx};
  end

  // Write channel: address and data are taken in either order.
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign s_axi_bresp   = 2'b00;
  assign clr_st = aw_got_r && w_got_r
                  && (aw_addr_r[11:2] == `QD_OFS_STATUS >> 2);
  assign clr_mask = w_strb_r[0] ? w_data_r[3:0] : 4'h0;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      aw_addr_r    <= 12'h000;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      ctrl_r       <= `QD_CTRL_RESET;
      tbase_r      <= `QD_TBASE_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (aw_got_r && w_got_r)
      begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_r[11:2] == `QD_OFS_CTRL >> 2)
        begin
          ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) & 32'hff3f_07ff;
          // A zero threshold is outside the legal range; keep the minimum.
          if (w_strb_r[2] && w_data_r[`QD_FILT_LSB +: 6] == 6'h00)
            ctrl_r[`QD_FILT_LSB +: 6] <= `QD_FILT_MIN;
        end
        if (aw_addr_r[11:2] == `QD_OFS_TBASE >> 2)
          tbase_r <= merge(tbase_r, w_data_r, w_strb_r);
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel.
  assign s_axi_arready = (rd_state_r == RD_IDLE);
  assign s_axi_rvalid  = (rd_state_r == RD_HOLD);
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rd_bad_r ? 2'b10 : 2'b00;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_state_r <= RD_IDLE;
      rdata_r    <= 32'h0000_0000;
      rd_bad_r   <= 1'b0;
    end
    else
    begin
      case (rd_state_r)
        RD_IDLE:
          if (s_axi_arvalid)
          begin
            rd_state_r <= RD_HOLD;
            rd_bad_r   <= 1'b0;
            case (s_axi_araddr[11:2])
              `QD_OFS_CTRL >> 2:   rdata_r <= ctrl_r;
              `QD_OFS_STATUS >> 2: rdata_r <= {23'h0, dir_r, 4'h0, flag_r};
              `QD_OFS_POS >> 2:    rdata_r <= 32'(pos_r);
              `QD_OFS_SPEED >> 2:  rdata_r <= speed_r;
              `QD_OFS_TBASE >> 2:  rdata_r <= tbase_r;
              default:
              begin
                rdata_r  <= 32'h0000_0000;
                rd_bad_r <= 1'b1;
              end
            endcase
          end
        RD_HOLD:
          if (s_axi_rready)
            rd_state_r <= RD_IDLE;
        default:
          rd_state_r <= RD_IDLE;
      endcase
    end
  end

  property p_mpe_zero;
    @(posedge clk) disable iff (!arst_n)
    (cmp_lim == 8'h00 && !flag_r[3]) |=> !flag_r[3] || cmp_lim != 8'h00;
  endproperty
  a_mpe_zero: assert property (p_mpe_zero) else $error("mpe with zero limit"); // [RULE14]

  property p_idx_flag;
    @(posedge clk) disable iff (!arst_n)
    ev_idx |=> flag_r[0];
  endproperty
  a_idx_flag: assert property (p_idx_flag) else $error("index flag lost"); // [RULE16]

  property p_dir_flag;
    @(posedge clk) disable iff (!arst_n)
    (step && dir_valid_r && fwd != dir_r) |=> flag_r[1];
  endproperty
  a_dir_flag: assert property (p_dir_flag) else $error("direction_change_flag lost"); // [RULE17]

  property p_quadrature_error_flag_hold;
    @(posedge clk) disable iff (!arst_n)
    (both_chg && !cfg.autocorrect) |=> $stable(pos_r);
  endproperty
  a_quadrature_error_flag_hold: assert property (p_quadrature_error_flag_hold) else $error("pos moved"); // [RULE20]

  property p_quadrature_error_flag_flag;
    @(posedge clk) disable iff (!arst_n)
    (both_chg && !cfg.transparent) |=> flag_r[2];
  endproperty
  a_quadrature_error_flag_flag: assert property (p_quadrature_error_flag_flag) else $error("quadrature_error_flag lost"); // [RULE18]

  property p_trans;
    @(posedge clk) disable iff (!arst_n)
    cfg.transparent |-> !ev_dir && !step;
  endproperty
  a_trans: assert property (p_trans) else $error("decode in transparent"); // [RULE5]

  property p_off;
    @(posedge clk) disable iff (!arst_n)
    !cfg.enable |-> !ev_idx && !edge_a && !edge_b;
  endproperty
  a_off: assert property (p_off) else $error("active when off"); // [RULE1]

  property p_pos_off;
    @(posedge clk) disable iff (!arst_n)
    (!cfg.pos_en && $past(!cfg.pos_en)) |-> $stable(pos_r);
  endproperty
  a_pos_off: assert property (p_pos_off) else $error("pos counted"); // [RULE3]

  property p_fwd_step;
    @(posedge clk) disable iff (!arst_n)
    (step && cnt_edge && fwd && cfg.pos_en) |=> pos_r == $past(pos_r) + 1'b1;
  endproperty
  a_fwd_step: assert property (p_fwd_step) else $error("fwd not up"); // [RULE19]
endmodule

// ### verification/encoder_model.sv
// Behavioural rotary encoder driving the two phase lines and the index line.
`timescale 1ns/100ps
module encoder_model
(
  input  wire logic clk,    // Stimulus clock.
  output logic      line_a, // Phase A level.
  output logic      line_b, // Phase B level.
  output logic      line_i  // Index level.
);
  logic [1:0] q;

  initial
  begin
    q = 2'b00;
    line_a = 1'b0;
    line_b = 1'b0;
    line_i = 1'b0;
  end

  // Order 00,10,11,01 makes phase A lead phase B when turning forward.
  // A step of zero moves two states at once, the way a lost pulse looks.
  task automatic step(input logic fwd, input int n, input int hold);
    repeat ((n == 0) ? 1 : n)
    begin
      @(posedge clk);
      q = (n == 0) ? q + 2'd2 : (fwd ? q + 2'd1 : q - 2'd1);
      line_a <= q[1] ^ q[0];
      line_b <= q[1];
      repeat (hold - 1) @(posedge clk);
    end
  endtask

  // A short excursion on phase A; the filter decides whether it counts.
  task automatic glitch(input int len);
    @(posedge clk);
    line_a <= ~line_a;
    repeat (len) @(posedge clk);
    line_a <= q[1] ^ q[0];
  endtask

  task automatic index(input logic v);
    @(posedge clk);
    line_i <= v;
  endtask
endmodule

// ### verification/quadrature_decoder_test.sv
// Register-level test of the quadrature decoder against an encoder model.
`timescale 1ns/100ps
`include "quadrature_decoder_map.svh"
module quadrature_decoder_test;
  localparam logic [10:0] EN   = 11'h001;
  localparam logic [10:0] POS  = 11'h002;
  localparam logic [10:0] SPD  = 11'h004;
  localparam logic [10:0] TR   = 11'h008;
  localparam logic [10:0] BOTH = 11'h010;
  localparam logic [10:0] INVERT_PHASE_A = 11'h020;
  localparam logic [10:0] INVERT_PHASE_B = 11'h040;
  localparam logic [10:0] INVI = 11'h080;
  localparam logic [10:0] EXCH = 11'h100;
  localparam logic [10:0] IDXB = 11'h200;
  localparam logic [10:0] AUTO = 11'h400;
  logic        clk;
  logic        arst_n;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp;
  logic [1:0]  br;
  logic        wvalid;
  logic        wready;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        enc_a;
  logic        enc_b;
  logic        enc_i;
  logic        idx_to_b;
  logic [31:0] rd;
  logic [1:0]  rr;
  logic [31:0] p;
  logic [10:0] mods [4] = '{INVERT_PHASE_A, INVERT_PHASE_B, EXCH, INVERT_PHASE_A | INVERT_PHASE_B};
  logic        dirs [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  int          n_mismatch;
  int          tests_run;

  always #2 clk = ~clk;

  encoder_model enc (.clk(clk), .line_a(enc_a), .line_b(enc_b),
                     .line_i(enc_i));

  quadrature_decoder DUT (
    .clk(clk), .arst_n(arst_n), .timer_line_a0(enc_a),
    // With the index moved to line B0, line A1 stays idle so that only
    // the selected pin can raise the index flag.
    .timer_line_b0(idx_to_b ? enc_i : enc_b),
    .timer_line_a1(enc_i & ~idx_to_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // Handshakes are judged at the falling edge so the sampled levels are
  // those the next rising edge will see, free of update races.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok)
    begin
      @(negedge clk);
      aw_ok = aw_ok | (awvalid & awready);
      w_ok = w_ok | (wvalid & wready);
      b_ok = bvalid;
      br = bresp;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] a);
    logic ar_ok;
    logic r_ok;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok)
    begin
      @(negedge clk);
      ar_ok = ar_ok | (arvalid & arready);
      r_ok = rvalid;
      rd = rdata;
      rr = rresp;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic ctl(input logic [10:0] b, input logic [5:0] f,
                     input logic [7:0] m);
    wr(`QD_OFS_CTRL, {m, 2'b00, f, 5'b00000, b});
    repeat (20) @(posedge clk);
    wr(`QD_OFS_STATUS, 32'h0000_000f);
  endtask

  // Moves the encoder and compares the position change; n of 0 is a jump.
  task automatic mv(input logic fwd, input int n, input logic [31:0] d);
    rdr(`QD_OFS_POS);
    p = rd;
    enc.step(fwd, n, 8);
    repeat (20) @(posedge clk);
    rdr(`QD_OFS_POS);
    check(rd - p, d);
    rdr(`QD_OFS_STATUS);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, idx_to_b, n_mismatch, tests_run} = '0;
    wstrb = 4'hf;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rdr(`QD_OFS_CTRL);
    check(rd, `QD_CTRL_RESET);
    rdr(`QD_OFS_TBASE);
    check(rd, `QD_TBASE_RESET);
    wr(12'h020, 32'hffff_ffff);
    check(br, 2'b00);
    rdr(12'h020);
    check(rd, 32'h0000_0000);
    check(rr, 2'b10);
    rdr(`QD_OFS_CTRL);
    check(rd, `QD_CTRL_RESET);
    // Only byte one is strobed, so the rest of the reset value survives.
    wstrb <= 4'h2;
    wr(`QD_OFS_TBASE, 32'h0000_1200);
    wstrb <= 4'hf;
    rdr(`QD_OFS_TBASE);
    check(rd, 32'h0000_12ff);
    ctl(POS | BOTH, 6'h00, 8'h00);
    rdr(`QD_OFS_CTRL);
    check(rd[21:16], 6'h01);
    $display("test registers done");
    mv(1'b1, 8, 32'h0);
    ctl(EN | POS | BOTH, 6'h01, 8'h00);
    mv(1'b1, 8, 32'h8);
    check(rd[`QD_ST_DIR], 1'b1);
    rdr(`QD_OFS_SPEED);
    check(rd, 32'h0);
    mv(1'b0, 4, -32'sd4);
    check(rd[`QD_ST_DIRECTION_CHANGE_FLAG], 1'b1);
    ctl(EN | POS, 6'h01, 8'h00);
    mv(1'b1, 8, 32'h4);
    wr(`QD_OFS_TBASE, 32'h0000_003f);
    ctl(EN | SPD | BOTH, 6'h01, 8'h00);
    // One edge every eight clocks over a 64-clock time base gives eight.
    // The read waits until a whole window has seen the encoder turning.
    fork
      enc.step(1'b1, 40, 8);
      begin
        repeat (200) @(posedge clk);
        rdr(`QD_OFS_SPEED);
      end
    join
    check(rd, 32'h0000_0008);
    mv(1'b1, 8, 32'h0);
    $display("test counting done");
    for (int i = 0; i < 4; i++)
    begin
      ctl(EN | POS | BOTH | mods[i], 6'h01, 8'h00);
      mv(1'b1, 4, dirs[i] ? 32'h0000_0004 : 32'hffff_fffc);
      check(rd[`QD_ST_DIR], dirs[i]);
    end
    ctl(EN | POS | BOTH | TR, 6'h01, 8'h00);
    enc.step(1'b1, 4, 8);
    mv(1'b0, 4, 32'h0);
    check(rd[`QD_ST_DIRECTION_CHANGE_FLAG], 1'b0);
    $display("test inversion done");
    ctl(EN | POS | BOTH, 6'h01, 8'h01);
    // A known direction is needed before autocorrect can add a step.
    mv(1'b1, 4, 32'h4);
    mv(1'b1, 0, 32'h0);
    check(rd[`QD_ST_QUADRATURE_ERROR_FLAG], 1'b1);
    check(rd[`QD_ST_MPE], 1'b0);
    ctl(EN | POS | BOTH | AUTO, 6'h01, 8'h00);
    mv(1'b1, 0, 32'h2);
    check(rd[`QD_ST_MPE], 1'b0);
    ctl(EN | POS | BOTH | AUTO, 6'h01, 8'h01);
    mv(1'b1, 0, 32'h2);
    check(rd[`QD_ST_MPE], 1'b1);
    $display("test missing pulse done");
    ctl(EN | POS | BOTH, 6'h06, 8'h00);
    enc.glitch(6);
    mv(1'b1, 4, 32'h4);
    ctl(EN | POS | BOTH, 6'h06, 8'h00);
    enc.glitch(6);
    repeat (20) @(posedge clk);
    rdr(`QD_OFS_STATUS);
    check(rd[`QD_ST_DIRECTION_CHANGE_FLAG], 1'b0);
    enc.glitch(7);
    repeat (20) @(posedge clk);
    rdr(`QD_OFS_STATUS);
    check(rd[`QD_ST_DIRECTION_CHANGE_FLAG], 1'b1);
    $display("test filter done");
    ctl(EN | POS, 6'h01, 8'h00);
    enc.index(1'b1);
    mv(1'b1, 0, 32'h0);
    check(rd[`QD_ST_IDX], 1'b1);
    enc.index(1'b0);
    ctl(EN | POS | INVI, 6'h01, 8'h00);
    enc.index(1'b1);
    mv(1'b1, 0, 32'h0);
    check(rd[`QD_ST_IDX], 1'b0);
    enc.index(1'b0);
    mv(1'b1, 0, 32'h0);
    check(rd[`QD_ST_IDX], 1'b1);
    idx_to_b <= 1'b1;
    ctl(EN | POS | IDXB, 6'h01, 8'h00);
    enc.index(1'b1);
    repeat (20) @(posedge clk);
    rdr(`QD_OFS_STATUS);
    check(rd[`QD_ST_IDX], 1'b1);
    $display("test index done");
    wrap_up();
  end
endmodule
